// ==== verilog/sdb_cfg.svh ====
// Constants for the structure and descriptor buffering block
`ifndef SDB_CFG_SVH
`define SDB_CFG_SVH
`define SDB_CCF_N 12
`define SDB_DB_N 8
`define SDB_HS_N 8
`define SDB_CD_N 8
`define SDB_R_CMD 8'h00
`define SDB_R_KEYLO 8'h04
`define SDB_R_KEYHI 8'h08
`define SDB_R_NAME 8'h30
`define SDB_R_SBASE 8'h34
`define SDB_R_ENV 8'h38
`define SDB_R_CDTOP 8'h3C
`define SDB_G_STAGE 4'h1
`define SDB_G_PROG_DESC_CTL_REG 4'h2
`define SDB_OP_PUSH 4'h1
`define SDB_OP_BRANCH 4'h2
`define SDB_OP_POP 4'h3
`define SDB_OP_LOOKUP 4'h4
`define SDB_OP_DWRITE 4'h5
`define SDB_OP_DFLUSH 4'h6
`define SDB_OP_CLOAD 4'h7
`define SDB_OP_CSAVE 4'h8
`define SDB_OP_COCALL 4'h9
`define SDB_OP_COACT 4'hA
`define SDB_OP_COEND 4'hB
`define SDB_OP_CWRITE 4'hC
`endif

// ==== verilog/sdb_pkg.sv ====
// Types of the structure and descriptor buffering block
`include "sdb_cfg.svh"
package sdb_pkg;
  typedef struct packed {
    logic        is_desc;
    logic [2:0]  attribute_length_field;
    logic [21:0] interp;
    logic [7:0]  seg;
    logic [47:0] container;
    logic [23:0] next_addr;
  } sdb_prog_desc_ctl_reg_t;
  typedef struct packed {
    logic [39:0] parent;
    logic [7:0]  lexic;
    logic [15:0] disp;
  } sdb_cd_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HWR  = 3'b001,
    S_HRD  = 3'b010,
    S_DWB  = 3'b011,
    S_DRD  = 3'b100,
    S_CRD  = 3'b101,
    S_CWR  = 3'b110
  } sdb_fsm_t;
  typedef struct packed {
    sdb_fsm_t                          st;
    logic [3:0]                        op;
    logic [3:0]                        idx;
    logic [3:0]                        left;
    logic                              first;
    logic [39:0]                       base;
    logic                              ack;
    logic [31:0]                       rdat;
    logic                              rq;
    logic                              rwe;
    logic [39:0]                       radr;
    logic [127:0]                      rwd;
    logic                              hitf;
    logic                              err;
    logic [127:0]                      stage;
    logic [127:0]                      res;
    logic [39:0]                       key;
    logic [23:0]                       name;
    logic [31:0]                       sbase;
    logic [31:0]                       env;
    sdb_prog_desc_ctl_reg_t                         prog_desc_ctl_reg;
    logic [`SDB_HS_N-1:0][105:0]       hist;
    logic [2:0]                        htop;
    logic [3:0]                        hcnt;
    logic [15:0]                       spilled;
    logic [`SDB_CD_N-1:0][63:0]        cd;
    logic [3:0]                        cdcnt;
    logic [`SDB_DB_N-1:0][127:0]       ddata;
    logic [`SDB_DB_N-1:0][39:0]        dtag;
    logic [`SDB_DB_N-1:0]              dval;
    logic [`SDB_DB_N-1:0]              ddirty;
    logic [2:0]                        dptr;
    logic [`SDB_CCF_N-1:0][127:0]      cdata;
    logic [`SDB_CCF_N-1:0][39:0]       ctag;
    logic [`SDB_CCF_N-1:0]             cval;
    logic [`SDB_CCF_N-1:0]             cdirty;
  } sdb_regs_t;
endpackage

// ==== verilog/sdb_struct_buf.sv ====
// Structure and descriptor buffering with level-1 link and Wishbone registers
// Behaviour
// - Control field buffer: twelve 128-bit data words, twelve 40-bit tags.
// - Each control field tag holds that word's level-1 address for write back.
// - Process return saves control field to environment area; process call reloads it.
// - Top display entry holds parent display and name of active control field.
// - Coroutine call replaces top name, writes old field back, loads new field.
// - Activate pushes a display entry; end pops the top entry.
// - One 106-bit control register and eight-deep 106-bit history stack.
// - Routine or loop entry pushes control register, then loads new description.
// - Branch overwrites control register without pushing history.
// - Call-type structure expression pushes register and loads called description.
// - First bit selects program or descriptor; next three bits descriptor only.
// - Then 22 attribute bits, segment, 48-bit container, 24-bit next address.
// - Descriptor buffer: eight 128-bit words, eight 40-bit tags with location.
// - Terminal reference is compared with tags; a match returns that entry.
// - Miss fills first empty entry, else overwrites the oldest entry.
// - Large descriptor occupies as many consecutive entries as it needs.
// - Modified descriptors are written back to level-1 storage.
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "sdb_cfg.svh"
module sdb_struct_buf
  import sdb_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Level-1 storage link
  output logic              l1_req_o,
  output logic              l1_we_o,
  output logic      [39:0]  l1_adr_o,
  output logic      [127:0] l1_dat_o,
  input  wire logic [127:0] l1_dat_i,
  input  wire logic         l1_ack_i
);
  import sdb_pkg::*;

  sdb_regs_t    q;
  sdb_regs_t    n;
  logic         psh;
  logic         hit;
  logic         fnd;
  logic [2:0]   hidx;
  logic [2:0]   vic;
  logic [2:0]   bot;
  logic         start;
  logic [31:0]  cmdw;
  logic [127:0] pv;
  logic [31:0]  stw;

  function automatic logic [31:0] wbm(input logic [31:0] o, input logic [31:0] d,
                                       input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        o[8*b +: 8] = d[8*b +: 8];
      end
    end
    return o;
  endfunction

  // Program objects leave the attribute length bits clear
  function automatic sdb_prog_desc_ctl_reg_t norm(input logic [127:0] v);
    sdb_prog_desc_ctl_reg_t p;
    p = v[105:0];
    if (!p.is_desc) begin
      p.attribute_length_field = 3'h0;
    end
    return p;
  endfunction

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign l1_req_o = q.rq;
  assign l1_we_o  = q.rwe;
  assign l1_adr_o = q.radr;
  assign l1_dat_o = q.rwd;

  always_comb begin
    n = q;
    psh = 1'b0;
    hit = 1'b0;
    hidx = 3'h0;
    fnd = 1'b0;
    vic = q.dptr;
    bot = q.htop - q.hcnt[2:0];
    pv = {22'h0, q.prog_desc_ctl_reg};
    stw = {q.dval, q.spilled[7:0], q.cdcnt, q.hcnt, 5'h0, q.err, q.hitf,
           (q.st != S_IDLE)};
    cmdw = wbm(32'h0, wb_dat_i, wb_sel_i);
    start = 1'b0;
    // Associative compare of the terminal reference
    for (int i = 0; i < `SDB_DB_N; i++) begin
      if (!hit && q.dval[i] && q.dtag[i] == q.key) begin
        hit = 1'b1;
        hidx = i[2:0];
      end
    end
    // Victim: first empty entry, else the oldest
    for (int i = 0; i < `SDB_DB_N; i++) begin
      if (!fnd && !q.dval[i]) begin
        fnd = 1'b1;
        vic = i[2:0];
      end
    end

    // Writes land at the edge that samples ack; reads answer one cycle after the strobe
    n.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack) begin
      if (wb_adr_i == `SDB_R_CMD) begin
        start = (q.st == S_IDLE);
      end else if (wb_adr_i == `SDB_R_KEYLO) begin
        n.key[31:0] = wbm(q.key[31:0], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SDB_R_KEYHI) begin
        n.key[39:32] = cmdw[7:0];
      end else if (wb_adr_i == `SDB_R_NAME) begin
        n.name = 24'(wbm({8'h0, q.name}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `SDB_R_SBASE) begin
        n.sbase = wbm(q.sbase, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SDB_R_ENV) begin
        n.env = wbm(q.env, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i[7:4] == `SDB_G_STAGE) begin
        n.stage[{wb_adr_i[3:2], 5'h0} +: 32] =
          wbm(q.stage[{wb_adr_i[3:2], 5'h0} +: 32], wb_dat_i, wb_sel_i);
      end
    end
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      n.ack = 1'b1;
      if (!wb_we_i) begin
        n.rdat = 32'h0;
        if (wb_adr_i == `SDB_R_CMD) begin
          n.rdat = stw;
        end else if (wb_adr_i == `SDB_R_KEYLO) begin
          n.rdat = q.key[31:0];
        end else if (wb_adr_i == `SDB_R_KEYHI) begin
          n.rdat = {24'h0, q.key[39:32]};
        end else if (wb_adr_i == `SDB_R_NAME) begin
          n.rdat = {8'h0, q.name};
        end else if (wb_adr_i == `SDB_R_SBASE) begin
          n.rdat = q.sbase;
        end else if (wb_adr_i == `SDB_R_ENV) begin
          n.rdat = q.env;
        end else if (wb_adr_i == `SDB_R_CDTOP) begin
          n.rdat = (q.cdcnt != 4'h0) ? q.cd[q.cdcnt[2:0] - 3'd1][31:0] : 32'h0;
        end else if (wb_adr_i[7:4] == `SDB_G_STAGE) begin
          n.rdat = q.res[{wb_adr_i[3:2], 5'h0} +: 32];
        end else if (wb_adr_i[7:4] == `SDB_G_PROG_DESC_CTL_REG) begin
          n.rdat = pv[{wb_adr_i[3:2], 5'h0} +: 32];
        end
      end
    end

    // Command start
    if (start) begin
      n.op = cmdw[3:0];
      n.err = 1'b0;
      n.idx = 4'h0;
      case (cmdw[3:0])
        `SDB_OP_PUSH: begin
          if (q.hcnt == 4'd8) begin
            n.st = S_HWR;
          end else begin
            psh = 1'b1;
          end
        end
        `SDB_OP_BRANCH: begin
          n.prog_desc_ctl_reg = norm(q.stage);
        end
        `SDB_OP_POP: begin
          if (q.hcnt != 4'h0) begin
            n.prog_desc_ctl_reg = q.hist[q.htop - 3'd1];
            n.htop = q.htop - 3'd1;
            n.hcnt = q.hcnt - 4'd1;
          end else if (q.spilled != 16'h0) begin
            n.st = S_HRD;
          end else begin
            n.err = 1'b1;
          end
        end
        `SDB_OP_LOOKUP: begin
          n.hitf = hit;
          if (hit) begin
            n.res = q.ddata[hidx];
          end else begin
            n.left = (cmdw[11:8] == 4'h0) ? 4'h1 : cmdw[11:8];
            n.idx = {1'b0, vic};
            n.base = q.key;
            n.first = 1'b1;
            n.st = S_DWB;
          end
        end
        `SDB_OP_DWRITE: begin
          if (hit) begin
            n.ddata[hidx] = q.stage;
            n.ddirty[hidx] = 1'b1;
          end else begin
            n.err = 1'b1;
          end
        end
        `SDB_OP_DFLUSH: begin
          n.st = S_DWB;
        end
        `SDB_OP_CLOAD: begin
          n.base = {8'h0, q.env};
          n.st = S_CRD;
        end
        `SDB_OP_CSAVE: begin
          n.st = S_CWR;
        end
        `SDB_OP_COCALL: begin
          if (q.cdcnt != 4'h0) begin
            n.cd[q.cdcnt[2:0] - 3'd1][23:0] = q.name;
          end
          n.st = S_CWR;
        end
        `SDB_OP_COACT: begin
          if (q.cdcnt == 4'd8) begin
            n.err = 1'b1;
          end else begin
            n.cd[q.cdcnt[2:0]] = q.stage[63:0];
            n.cdcnt = q.cdcnt + 4'd1;
          end
        end
        `SDB_OP_COEND: begin
          if (q.cdcnt == 4'h0) begin
            n.err = 1'b1;
          end else begin
            n.cdcnt = q.cdcnt - 4'd1;
          end
        end
        `SDB_OP_CWRITE: begin
          if (cmdw[11:8] < 4'd12) begin
            n.cdata[cmdw[11:8]] = q.stage;
            n.cval[cmdw[11:8]] = 1'b1;
            n.cdirty[cmdw[11:8]] = 1'b1;
          end else begin
            n.err = 1'b1;
          end
        end
        default: begin
          n.err = 1'b1;
        end
      endcase
    end

    // Level-1 sequencing
    case (q.st)
      S_IDLE: begin
      end
      S_HWR: begin
        if (l1_ack_i) begin
          n.spilled = q.spilled + 16'd1;
          n.hcnt = q.hcnt - 4'd1;
          psh = 1'b1;
          n.st = S_IDLE;
        end
      end
      S_HRD: begin
        if (l1_ack_i) begin
          n.prog_desc_ctl_reg = l1_dat_i[105:0];
          n.spilled = q.spilled - 16'd1;
          n.st = S_IDLE;
        end
      end
      S_DWB: begin
        if (!q.rq || l1_ack_i) begin
          if (q.rq) begin
            n.ddirty[q.idx[2:0]] = 1'b0;
          end
          if (q.op == `SDB_OP_DFLUSH) begin
            n.idx = q.idx + 4'd1;
            if (q.idx == 4'd7) begin
              n.st = S_IDLE;
            end
          end else begin
            n.st = S_DRD;
          end
        end
      end
      S_DRD: begin
        if (l1_ack_i) begin
          n.ddata[q.idx[2:0]] = l1_dat_i;
          n.dtag[q.idx[2:0]] = q.base;
          n.dval[q.idx[2:0]] = 1'b1;
          n.ddirty[q.idx[2:0]] = 1'b0;
          n.dptr = q.idx[2:0] + 3'd1;
          n.first = 1'b0;
          if (q.first) begin
            n.res = l1_dat_i;
          end
          n.left = q.left - 4'd1;
          if (q.left == 4'd1) begin
            n.st = S_IDLE;
          end else begin
            n.idx = {1'b0, q.idx[2:0] + 3'd1};
            n.base = q.base + 40'd1;
            n.st = S_DWB;
          end
        end
      end
      S_CRD: begin
        if (l1_ack_i) begin
          n.cdata[q.idx] = l1_dat_i;
          n.ctag[q.idx] = q.base + {36'h0, q.idx};
          n.cval[q.idx] = 1'b1;
          n.cdirty[q.idx] = 1'b0;
          n.idx = q.idx + 4'd1;
          if (q.idx == 4'd11) begin
            n.st = S_IDLE;
          end
        end
      end
      S_CWR: begin
        if (!q.rq || l1_ack_i) begin
          if (q.rq && q.op == `SDB_OP_COCALL) begin
            n.cdirty[q.idx] = 1'b0;
          end
          n.idx = q.idx + 4'd1;
          if (q.idx == 4'd11) begin
            n.idx = 4'h0;
            n.st = S_IDLE;
            if (q.op == `SDB_OP_COCALL) begin
              n.base = q.key;
              n.st = S_CRD;
            end
          end
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    // Push the control register, then load the new description
    if (psh) begin
      n.hist[q.htop] = q.prog_desc_ctl_reg;
      n.htop = q.htop + 3'd1;
      n.hcnt = n.hcnt + 4'd1;
      n.prog_desc_ctl_reg = norm(q.stage);
    end

    // Level-1 request for the next state
    n.rq = 1'b0;
    n.rwe = 1'b0;
    n.radr = 40'h0;
    n.rwd = 128'h0;
    case (n.st)
      S_IDLE: begin
      end
      S_HWR: begin
        n.rq = 1'b1;
        n.rwe = 1'b1;
        n.radr = {8'h0, q.sbase} + {24'h0, n.spilled};
        n.rwd = {22'h0, q.hist[bot]};
      end
      S_HRD: begin
        n.rq = 1'b1;
        n.radr = {8'h0, q.sbase} + {24'h0, q.spilled} - 40'd1;
      end
      S_DWB: begin
        n.rq = n.dval[n.idx[2:0]] && n.ddirty[n.idx[2:0]];
        n.rwe = 1'b1;
        n.radr = n.dtag[n.idx[2:0]];
        n.rwd = n.ddata[n.idx[2:0]];
      end
      S_DRD: begin
        n.rq = 1'b1;
        n.radr = n.base;
      end
      S_CRD: begin
        n.rq = 1'b1;
        n.radr = n.base + {36'h0, n.idx};
      end
      S_CWR: begin
        n.rwe = 1'b1;
        n.rwd = n.cdata[n.idx];
        if (n.op == `SDB_OP_COCALL) begin
          n.rq = n.cval[n.idx] && n.cdirty[n.idx];
          n.radr = n.ctag[n.idx];
        end else begin
          n.rq = n.cval[n.idx];
          n.radr = {8'h0, q.env} + {36'h0, n.idx};
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ==== tb/sdb_struct_buf_monitor.sv ====
// Port checker for the structure and descriptor buffering block
`timescale 1ns/1ns
module sdb_struct_buf_monitor (
  // Clock and reset
  input wire logic         clk_i,
  input wire logic         rst_i,
  // Wishbone slave
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [7:0]   wb_adr_i,
  input wire logic [3:0]   wb_sel_i,
  input wire logic [31:0]  wb_dat_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  // Level-1 storage link
  input wire logic         l1_req_o,
  input wire logic         l1_we_o,
  input wire logic [39:0]  l1_adr_o,
  input wire logic [127:0] l1_dat_o,
  input wire logic [127:0] l1_dat_i,
  input wire logic         l1_ack_i
);
  logic take;
  logic rd_take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_take = take && !wb_we_i;
  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_take:
    assert property (take |=> wb_ack_o) else $error("ack missing");
  a_ack_one_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  a_rdat_holds:
    assert property (!rd_take |=> $stable(wb_dat_o)) else $error("read data moved");
  a_unmapped_zero:
    assert property (rd_take && wb_adr_i[7:6] != 2'b00 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
  a_ctl_top_zero:
    assert property (rd_take && wb_adr_i == 8'h2C |=> wb_dat_o[31:10] == 22'h0)
      else $error("control word too wide");
  a_l1_req_held:
    assert property (l1_req_o && !l1_ack_i |=> l1_req_o) else $error("request dropped");
  a_l1_fields_hold:
    assert property (l1_req_o && !l1_ack_i |=> $stable(l1_adr_o) && $stable(l1_we_o)
      && $stable(l1_dat_o)) else $error("request changed");
endmodule
bind sdb_struct_buf sdb_struct_buf_monitor sdb_struct_buf_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .l1_req_o(l1_req_o), .l1_we_o(l1_we_o), .l1_adr_o(l1_adr_o),
  .l1_dat_o(l1_dat_o), .l1_dat_i(l1_dat_i), .l1_ack_i(l1_ack_i)
);

// ==== tb/sdb_l1_model.sv ====
// Behavioural level-1 storage answering the block's word requests
`timescale 1ns/1ns
module sdb_l1_model (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Request side
  input  wire logic         req_i,
  input  wire logic         we_i,
  input  wire logic [39:0]  adr_i,
  input  wire logic [127:0] dat_i,
  input  wire logic         slow_i,
  // Answer side
  output logic      [127:0] dat_o,
  output logic              ack_o
);
  logic [127:0] mem [logic [39:0]];
  logic [3:0]   wait_q;
  // Unwritten words read back as a pattern made from their address
  function automatic logic [127:0] peek(input logic [39:0] a);
    if (mem.exists(a))
      return mem[a];
    return {~a[31:0], a[31:0], a[31:0] ^ 32'h5A5A0000, 32'hC3C3C3C3};
  endfunction
  // Outside an answer the data lines toggle so stale data never looks valid
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      dat_o <= 128'h0;
    end else if (req_i && !ack_o && wait_q >= (slow_i ? 4'h5 : 4'h0)) begin
      ack_o <= 1'b1;
      wait_q <= 4'h0;
      if (we_i)
        mem[adr_i] = dat_i;
      else
        dat_o <= peek(adr_i);
    end else begin
      ack_o <= 1'b0;
      dat_o <= ~dat_o;
      if (req_i && !ack_o)
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the structure and descriptor buffering block
`timescale 1ns/1ns
`include "sdb_cfg.svh"
module testbench;
  import sdb_pkg::*;
  logic         clk_i, rst_i, cyc, stb, we;
  logic         want, slow, ack, l1_req, l1_we, l1_ack;
  logic [3:0]   sel, bsel;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat, dat_o, eq[$], mq[$];
  logic [39:0]  l1_adr;
  logic [127:0] l1_wd, l1_rd, s;
  logic [105:0] v, hq[$];
  int           n_mismatch = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  sdb_struct_buf sdb_struct_buf_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .l1_req_o(l1_req), .l1_we_o(l1_we), .l1_adr_o(l1_adr),
    .l1_dat_o(l1_wd), .l1_dat_i(l1_rd), .l1_ack_i(l1_ack));
  sdb_l1_model sdb_l1_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(l1_req), .we_i(l1_we),
    .adr_i(l1_adr), .dat_i(l1_wd), .slow_i(slow), .dat_o(l1_rd), .ack_o(l1_ack));
  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input logic [127:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got & m, exp & m);
    end
  endtask
  // Checked read answers are held against the oldest noted value
  always @(posedge clk_i) begin
    if (ack === 1'b1 && want === 1'b1)
      cmp({96'h0, dat_o}, {96'h0, eq.pop_front()}, {96'h0, mq.pop_front()});
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    want <= c;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    want <= 1'b0;
    if (k == 50) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = ~32'h0);
    eq.push_back(e);
    mq.push_back(m);
    wb(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic put(input logic [127:0] d);
    for (int i = 0; i < 4; i++)
      wb(1'b1, 8'h10 + 8'(4 * i), d[32 * i +: 32], 1'b0);
  endtask
  task automatic chk(input logic [7:0] a, input logic [127:0] e);
    for (int i = 0; i < 4; i++)
      rd(a + 8'(4 * i), e[32 * i +: 32]);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] arg = 4'h0);
    int k;
    wb(1'b1, `SDB_R_CMD, {20'h0, arg, 4'h0, op}, 1'b0);
    for (k = 0; k < 100; k++) begin
      wb(1'b0, `SDB_R_CMD, 32'h0, 1'b0);
      if (rdat[0] === 1'b0)
        break;
    end
    if (k == 100) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // Argument F only loads the key without a lookup
  task automatic look(input logic [39:0] k, input logic [3:0] n);
    wb(1'b1, `SDB_R_KEYLO, k[31:0], 1'b0);
    wb(1'b1, `SDB_R_KEYHI, {24'h0, k[39:32]}, 1'b0);
    if (n != 4'hF)
      cmd(`SDB_OP_LOOKUP, n);
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    want = 1'b0;
    slow = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    bsel = 4'hF;
    void'($urandom(32'hBF03));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SDB_R_CMD, 32'h0);
    chk(8'h20, 128'h0);
    rd(8'hF0, 32'h0);
    wb(1'b1, `SDB_R_SBASE, 32'h00001000, 1'b0);
    hq.push_back(106'h0);
    for (int i = 0; i < 10; i++) begin
      s = {$urandom, $urandom, $urandom, $urandom};
      s[105] = i[0];
      v = s[105:0];
      if (!v[105])
        v[104:102] = 3'h0;
      slow <= s[0];
      put(s);
      cmd(`SDB_OP_PUSH);
      chk(8'h20, {22'h0, v});
      hq.push_back(v);
    end
    rd(`SDB_R_CMD, 32'h00020800);
    s = {$urandom, $urandom, $urandom, $urandom};
    s[105] = 1'b1;
    put(s);
    cmd(`SDB_OP_BRANCH);
    chk(8'h20, {22'h0, s[105:0]});
    rd(`SDB_R_CMD, 32'h00020800);
    for (int i = 0; i < 10; i++) begin
      cmd(`SDB_OP_POP);
      void'(hq.pop_back());
      chk(8'h20, {22'h0, hq[hq.size() - 1]});
    end
    cmd(`SDB_OP_POP);
    rd(`SDB_R_CMD, 32'h4, 32'h4);
    bsel = 4'h6;
    wb(1'b1, `SDB_R_SBASE, 32'hA5A5A5A5, 1'b0);
    bsel = 4'hF;
    rd(`SDB_R_SBASE, 32'h00A5A500);
    look(40'h2000, 4'h0);
    rd(`SDB_R_CMD, 32'h01000000, 32'hFF000002);
    chk(8'h10, sdb_l1_model_inst.peek(40'h2000));
    look(40'h2000, 4'h0);
    rd(`SDB_R_CMD, 32'h01000002, 32'hFF000002);
    look(40'h2100, 4'h2);
    rd(`SDB_R_CMD, 32'h07000000, 32'hFF000002);
    look(40'h2101, 4'h0);
    rd(`SDB_R_CMD, 32'h07000002, 32'hFF000002);
    chk(8'h10, sdb_l1_model_inst.peek(40'h2101));
    for (int i = 0; i < 6; i++)
      look(40'h2200 + 40'(i), 4'h0);
    look(40'h2000, 4'h0);
    rd(`SDB_R_CMD, 32'hFF000000, 32'hFF000002);
    look(40'h2203, 4'h0);
    s = {$urandom, $urandom, $urandom, $urandom};
    put(s);
    cmd(`SDB_OP_DWRITE);
    cmd(`SDB_OP_DFLUSH);
    cmp(sdb_l1_model_inst.peek(40'h2203), s, ~128'h0);
    wb(1'b1, `SDB_R_ENV, 32'h00004000, 1'b0);
    wb(1'b1, `SDB_R_NAME, 32'h00123456, 1'b0);
    put(s);
    cmd(`SDB_OP_COACT);
    rd(`SDB_R_CDTOP, s[31:0]);
    rd(`SDB_R_CMD, 32'h00001000, 32'h0000F004);
    look(40'h3000, 4'hF);
    cmd(`SDB_OP_COCALL);
    rd(`SDB_R_CDTOP, {s[31:24], 24'h123456});
    cmd(`SDB_OP_CSAVE);
    cmp(sdb_l1_model_inst.peek(40'h4000), sdb_l1_model_inst.peek(40'h3000), ~128'h0);
    s = {$urandom, $urandom, $urandom, $urandom};
    put(s);
    cmd(`SDB_OP_CWRITE, 4'hB);
    look(40'h3100, 4'hF);
    cmd(`SDB_OP_COCALL);
    cmp(sdb_l1_model_inst.peek(40'h300B), s, ~128'h0);
    cmd(`SDB_OP_COEND);
    rd(`SDB_R_CMD, 32'h0, 32'h0000F004);
    cmd(`SDB_OP_COEND);
    rd(`SDB_R_CMD, 32'h4, 32'h4);
    wrap_up();
  end
endmodule
